// File: rtl/xcvr_mode_idle_ctrl.sv
module xcvr_mode_idle_ctrl #(
    parameter int NCH = xcvr_pkg::NCH_DEF,
    parameter int LOCK_CYCLES = xcvr_pkg::LOCK_CYCLES_DEF,
    parameter int BIT_DIV = xcvr_pkg::BIT_DIV_DEF,
    parameter int RXCLK_HALF = xcvr_pkg::RXCLK_HALF_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [xcvr_pkg::AW-1:0] reg_addr,
    input wire logic [xcvr_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [xcvr_pkg::DW-1:0] reg_rdata,
    output logic irq,
    // configuration pins
    input wire logic iface_select,
    input wire logic output_enable,
    input wire logic channel_clock_select,
    input wire logic busy_mode_input,
    input wire logic ethernet_mode_pin,
    input wire logic pattern_test_enable,
    input wire logic pll_power_down,
    output logic pll_lock,
    output logic nibble_mode,
    output logic outputs_oe,
    // transmit parallel side
    input wire logic shared_tx_clock,
    input wire logic [NCH-1:0] per_channel_tx_clock,
    input wire xcvr_pkg::code_char_s [NCH-1:0] tx_char,
    output xcvr_pkg::code_char_s [NCH-1:0] tx_code_out,
    output logic [NCH-1:0] tx_code_valid,
    output logic [NCH-1:0] idle_deletable,
    // receive clocks
    output logic shared_rx_clock,
    output logic [NCH-1:0] per_channel_rx_byte_clock,
    // serial test side
    output logic [NCH-1:0] tx_serial,
    input wire logic [NCH-1:0] rx_serial
);
    import xcvr_pkg::*;

    localparam int LCW = $clog2(LOCK_CYCLES + 1);
    localparam int BDW = $clog2(BIT_DIV + 1);
    localparam int RCW = $clog2(RXCLK_HALF + 1);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [6:0] pin_s1_reg;
    logic [6:0] pin_s2_reg;
    logic [NCH:0] tclk_s1_reg;
    logic [NCH:0] tclk_s2_reg;
    logic [NCH:0] tclk_s3_reg;
    code_char_s [NCH-1:0] txc_s1_reg;
    code_char_s [NCH-1:0] txc_s2_reg;
    logic [NCH-1:0] rxs_s1_reg;
    logic [NCH-1:0] rxs_s2_reg;

    // every pin passes two flops before any logic looks at it
    always_ff @(posedge clk_sys)
    begin
        pin_s1_reg <= {iface_select, output_enable, channel_clock_select, busy_mode_input,
                       ethernet_mode_pin, pattern_test_enable, pll_power_down};
        pin_s2_reg <= pin_s1_reg;
        tclk_s1_reg <= {per_channel_tx_clock, shared_tx_clock};
        tclk_s2_reg <= tclk_s1_reg;
        tclk_s3_reg <= tclk_s2_reg;
        txc_s1_reg <= tx_char;
        txc_s2_reg <= txc_s1_reg;
        rxs_s1_reg <= rx_serial;
        rxs_s2_reg <= rxs_s1_reg;
    end

    wire iface_s;
    wire oe_s;
    wire clksel_s;
    wire busy_s;
    wire ge_pin_s;
    wire prbs_s;
    wire pd_s;
    assign {iface_s, oe_s, clksel_s, busy_s, ge_pin_s, prbs_s, pd_s} = pin_s2_reg;
    // data settle through the same two flops, so they line up with the edge
    wire [NCH:0] tclk_rise = tclk_s2_reg & ~tclk_s3_reg;

    // ************************************************************
    // registers
    // ************************************************************
    logic clk_mode_bit_reg;
    logic ethernet_mode_bit_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [NCH-1:0] prbs_err_reg;
    logic [NCH-1:0] prbs_lock_reg;

    // clock mode from pin or register
    wire clk_mode_eff = clksel_s | clk_mode_bit_reg;
    // Ethernet mode from pin or register
    wire ge_eff = ge_pin_s | ethernet_mode_bit_reg;

    wire wr_clk = reg_wr && reg_addr == ADDR_CLK_CTRL;
    wire wr_ge = reg_wr && reg_addr == ADDR_GE_CTRL;
    wire wr_mask = reg_wr && reg_addr == ADDR_IRQ_MASK;
    wire rd_irq = reg_rd && reg_addr == ADDR_IRQ_STAT;
    wire rd_prbs = reg_rd && reg_addr == ADDR_PRBS;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            clk_mode_bit_reg <= 1'b0;
            ethernet_mode_bit_reg <= 1'b0;
            irq_mask_reg <= IRQ_RESET;
        end
        else
        begin
            if (wr_clk)
                clk_mode_bit_reg <= reg_wdata[CLK_MODE_POS];
            if (wr_ge)
                ethernet_mode_bit_reg <= reg_wdata[GE_MODE_POS];
            if (wr_mask)
                irq_mask_reg <= reg_wdata[IRQ_W-1:0];
        end
    end

    // read mux; unmapped addresses read zero
    logic [DW-1:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        case (reg_addr)
            ADDR_STATUS:
                rd_mux[6:0] = {oe_s, pll_lock, prbs_s, busy_s, iface_s, ge_eff, clk_mode_eff};
            ADDR_PRBS:
            begin
                rd_mux[NCH-1:0] = prbs_lock_reg;
                rd_mux[PRBS_ERR_LSB +: NCH] = prbs_err_reg;
            end
            ADDR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_reg;
            ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
            ADDR_CLK_CTRL: rd_mux[CLK_MODE_POS] = clk_mode_bit_reg;
            ADDR_GE_CTRL: rd_mux[GE_MODE_POS] = ethernet_mode_bit_reg;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rd_mux;
    end

    // ************************************************************
    // lock timer
    // ************************************************************
    logic [LCW-1:0] lock_cnt_reg;
    logic lock_evt;

    // lock shows only once the full lock time has run out
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || pd_s)
        begin
            lock_cnt_reg <= '0;
            pll_lock <= 1'b0;
        end
        else
        begin
            if (lock_cnt_reg != LCW'(LOCK_CYCLES))
                lock_cnt_reg <= lock_cnt_reg + 1'b1;
            pll_lock <= lock_cnt_reg == LCW'(LOCK_CYCLES);
        end
    end
    assign lock_evt = !pll_lock && !pd_s && lock_cnt_reg == LCW'(LOCK_CYCLES);

    // ************************************************************
    // dividers: serial bit rate and receive byte clock
    // ************************************************************
    logic [BDW-1:0] bit_cnt_reg;
    logic [RCW-1:0] rxc_cnt_reg;
    logic rxc_phase_reg;
    wire bit_en = bit_cnt_reg == BDW'(BIT_DIV - 1);
    wire rxc_en = rxc_cnt_reg == RCW'(RXCLK_HALF - 1);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            bit_cnt_reg <= '0;
            rxc_cnt_reg <= '0;
            rxc_phase_reg <= 1'b0;
        end
        else
        begin
            bit_cnt_reg <= bit_en ? '0 : bit_cnt_reg + 1'b1;
            rxc_cnt_reg <= rxc_en ? '0 : rxc_cnt_reg + 1'b1;
            if (rxc_en)
                rxc_phase_reg <= ~rxc_phase_reg;
        end
    end

    // receive clocks; the unused group is held low
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            shared_rx_clock <= 1'b0;
            per_channel_rx_byte_clock <= '0;
        end
        else
        begin
            per_channel_rx_byte_clock <= clk_mode_eff ? {NCH{rxc_phase_reg}} : '0;
            shared_rx_clock <= clk_mode_eff ? 1'b0 : rxc_phase_reg;
        end
    end

    // ************************************************************
    // mode status outputs
    // ************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            nibble_mode <= 1'b0;
            outputs_oe <= 1'b0;
        end
        else
        begin
            // interface mode follows the select pin
            nibble_mode <= iface_s;
            // the enable pin drives outputs_oe and status bit 6; no output here is gated by it
            outputs_oe <= oe_s;
        end
    end

    // ************************************************************
    // per-channel idle handling and pattern test
    // ************************************************************
    idle_corr_e corr_reg [NCH];
    idle_corr_e corr_next [NCH];
    logic [NCH-1:0] prev_k285_reg;
    logic [NCH-1:0] corr_off_evt;
    logic [NCH-1:0] prbs_err_evt;
    logic [PRBS_W-1:0] gen_reg [NCH];
    logic [PRBS_W-1:0] chk_reg [NCH];
    logic [2:0] match_cnt_reg [NCH];

    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        // own clock in independent mode; shared clock otherwise
        wire tx_stb = clk_mode_eff ? tclk_rise[i + 1] : tclk_rise[0];
        code_char_s cur;
        assign cur = txc_s2_reg[i];
        wire is_k285 = cur.k && cur.d == K28_5;
        wire is_data = !cur.k;
        wire pair = prev_k285_reg[i] && is_data;
        wire corr_en = corr_reg[i] == CORR_ON || corr_reg[i] == CORR_K1;
        // swap the disparity-fixing character into the idle pair
        wire fix = ge_eff && corr_en && pair && cur.d == D16_2;
        // busy mode keeps K28.5 D10.1 as data
        wire deletable = pair && (busy_s ? (ge_eff && cur.d != D10_1)
                                         : (ge_eff || cur.d == D10_1));

        // correction stops on K28.5 runs, resumes after two data
        always_comb
        begin
            corr_next[i] = corr_reg[i];
            case (corr_reg[i])
                CORR_ON: if (is_k285) corr_next[i] = CORR_K1;
                CORR_K1: corr_next[i] = is_k285 ? CORR_OFF : CORR_ON;
                CORR_OFF: if (is_data) corr_next[i] = CORR_D1;
                CORR_D1: corr_next[i] = is_data ? CORR_ON : CORR_OFF;
                default: corr_next[i] = CORR_ON;
            endcase
        end
        assign corr_off_evt[i] = tx_stb && corr_reg[i] != CORR_OFF && corr_next[i] == CORR_OFF;

        always_ff @(posedge clk_sys)
        begin
            if (sys_rst)
            begin
                corr_reg[i] <= CORR_ON;
                prev_k285_reg[i] <= 1'b0;
                tx_code_out[i] <= CHAR_RESET;
                tx_code_valid[i] <= 1'b0;
                idle_deletable[i] <= 1'b0;
            end
            else
            begin
                tx_code_valid[i] <= tx_stb;
                if (tx_stb)
                begin
                    corr_reg[i] <= corr_next[i];
                    prev_k285_reg[i] <= is_k285;
                    tx_code_out[i] <= fix ? code_char_s'{k: 1'b0, d: D5_6} : cur;
                    idle_deletable[i] <= deletable;
                end
            end
        end

        // x^7 + x^6 + 1 for both generator and checker
        wire gen_fb = gen_reg[i][6] ^ gen_reg[i][5];
        wire rx_bit = rxs_s2_reg[i];
        wire predict = chk_reg[i][6] ^ chk_reg[i][5];
        wire miss = rx_bit != predict;
        assign prbs_err_evt[i] = prbs_s && bit_en && prbs_lock_reg[i] && miss;

        // generator on the serial output, checker on the input
        always_ff @(posedge clk_sys)
        begin
            if (sys_rst || !prbs_s)
            begin
                gen_reg[i] <= PRBS_SEED;
                chk_reg[i] <= '0;
                match_cnt_reg[i] <= '0;
                prbs_lock_reg[i] <= 1'b0;
                tx_serial[i] <= 1'b0;
            end
            else if (bit_en)
            begin
                gen_reg[i] <= {gen_reg[i][5:0], gen_fb};
                tx_serial[i] <= gen_reg[i][6];
                chk_reg[i] <= {chk_reg[i][5:0], rx_bit};
                // seven clean bits in a row before errors count
                if (!prbs_lock_reg[i])
                begin
                    match_cnt_reg[i] <= miss ? '0 : match_cnt_reg[i] + 1'b1;
                    prbs_lock_reg[i] <= !miss && match_cnt_reg[i] == PRBS_LOCK_MATCHES - 3'h1;
                end
            end
        end
    end

    // sticky error bits, cleared by reading them; a new error wins
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            prbs_err_reg <= '0;
        else
            prbs_err_reg <= (rd_prbs ? '0 : prbs_err_reg) | prbs_err_evt;
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    wire [IRQ_W-1:0] irq_set = {|prbs_err_evt, |corr_off_evt, lock_evt};

    // a read clears the status, but an event in the same cycle survives
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            irq_stat_reg <= IRQ_RESET;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (rd_irq ? IRQ_RESET : irq_stat_reg) | irq_set;
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule : xcvr_mode_idle_ctrl

// File: rtl/xcvr_pkg.sv
package xcvr_pkg;

    // ************************************************************
    // sizes and timing
    // ************************************************************
    localparam int NCH_DEF = 8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PLL_LOCK_TIME_US = 100;
    // least time, so round up to whole cycles
    localparam int LOCK_CYCLES_DEF =
        (PLL_LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_DIV_DEF = 4;
    localparam int RXCLK_HALF_DEF = 4;
    localparam int PRBS_W = 7;
    localparam logic [PRBS_W-1:0] PRBS_SEED = 7'h7F;
    localparam logic [2:0] PRBS_LOCK_MATCHES = 3'h7;

    // ************************************************************
    // code characters
    // ************************************************************
    localparam logic [7:0] K28_5 = 8'hBC;
    localparam logic [7:0] D10_1 = 8'h2A;
    localparam logic [7:0] D16_2 = 8'h50;
    localparam logic [7:0] D5_6 = 8'hC5;

    typedef struct packed {
        logic k;
        logic [7:0] d;
    } code_char_s;

    localparam code_char_s CHAR_RESET = '{k: 1'b0, d: 8'h00};

    typedef enum logic [1:0] {
        CORR_ON = 2'b00,
        CORR_K1 = 2'b01,
        CORR_OFF = 2'b10,
        CORR_D1 = 2'b11
    } idle_corr_e;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h00;
    localparam logic [AW-1:0] ADDR_PRBS = 8'h08;
    localparam logic [AW-1:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [AW-1:0] ADDR_CLK_CTRL = 8'h44;
    localparam logic [AW-1:0] ADDR_GE_CTRL = 8'h60;
    localparam int CLK_MODE_POS = 15;
    localparam int GE_MODE_POS = 15;
    localparam int PRBS_ERR_LSB = 8;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

endpackage : xcvr_pkg

// File: tb/mode_idle_checker_asserts.sv
// ************
// pin and timing checks on the top ports
// ************
module mode_idle_checker #(
    parameter int NCH = 8,
    parameter int LOCK_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [xcvr_pkg::DW-1:0] reg_rdata,
    input wire logic iface_select,
    input wire logic output_enable,
    input wire logic channel_clock_select,
    input wire logic pattern_test_enable,
    input wire logic pll_power_down,
    input wire logic pll_lock,
    input wire logic nibble_mode,
    input wire logic outputs_oe,
    input wire logic shared_rx_clock,
    input wire logic [NCH-1:0] per_channel_rx_byte_clock,
    input wire logic [NCH-1:0] tx_serial
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // cycles since the lock timer was last held; saturates so it never wraps
    int unsigned up_cnt;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || pll_power_down)
            up_cnt <= 0;
        else if (up_cnt < LOCK_CYCLES)
            up_cnt <= up_cnt + 1;
    end
    oe_on_a: assert property (output_enable [*4] |=> outputs_oe)
        else $error("outputs_oe low with enable high");
    oe_off_a: assert property (!output_enable [*4] |=> !outputs_oe)
        else $error("outputs_oe high with enable low");
    nibble_on_a: assert property (iface_select [*4] |=> nibble_mode)
        else $error("nibble_mode missing");
    rx_shared_a: assert property (channel_clock_select [*6] |=> !shared_rx_clock)
        else $error("shared rx clock runs in independent mode");
    rx_group_a: assert property (per_channel_rx_byte_clock inside {'0, {NCH{1'b1}}})
        else $error("channel rx clocks differ");
    lock_hold_a: assert property (pll_power_down [*3] |=> !pll_lock)
        else $error("lock high in power-down");
    lock_late_a: assert property ($rose(pll_lock) |-> up_cnt >= LOCK_CYCLES)
        else $error("lock rose too early");
    prbs_idle_a: assert property (!pattern_test_enable [*4] |=> tx_serial == '0)
        else $error("serial output active without pattern test");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule : mode_idle_checker

// File: tb/mac_model.sv
// protocol side: one link clock pulse per character, loopback on the serial side
module mac_model #(
    parameter int NCH = 8
) (
    input wire logic req,
    input wire xcvr_pkg::code_char_s next_char,
    input wire logic flip_bit,
    input wire logic [NCH-1:0] tx_serial,
    output logic link_clk,
    output xcvr_pkg::code_char_s [NCH-1:0] tx_char,
    output logic [NCH-1:0] rx_serial
);
    timeunit 1ns;
    timeprecision 100ps;
    import xcvr_pkg::*;
    initial
    begin
        link_clk = 1'b0;
        tx_char = '1;
    end
    // host sends whole characters; clock stands still between them
    always @(req)
    begin
        tx_char = {NCH{next_char}};
        #62.5 link_clk = 1'b1;
        #62.5 link_clk = 1'b0;
        tx_char = ~tx_char; // hold time over, so the old value must not linger
    end
    // far end returns the pattern, flip_bit corrupts it
    assign rx_serial = tx_serial ^ {NCH{flip_bit}};
endmodule : mac_model

// File: tb/xcvr_mode_idle_ctrl_tb.sv
module xcvr_mode_idle_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import xcvr_pkg::*;
    localparam int N = 8;
    localparam code_char_s KC = '{k: 1'b1, d: K28_5};
    logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [AW-1:0] reg_addr = '0;
    logic [DW-1:0] reg_wdata = '0, reg_rdata, rd;
    logic irq, pll_lock, nibble_mode, outputs_oe, shared_rx_clock, link_clk;
    logic iface_select = 0, output_enable = 1, channel_clock_select = 0;
    logic busy_mode_input = 0, ethernet_mode_pin = 0, pattern_test_enable = 0;
    logic pll_power_down = 0, req = 0, flip = 0, m_on = 1, m_prevk = 0;
    code_char_s next_char = CHAR_RESET;
    code_char_s [N-1:0] tx_char, tx_code_out;
    logic [N-1:0] tx_code_valid, idle_deletable, per_channel_rx_byte_clock, tx_serial, rx_serial;
    int miscompares = 0, num_checks = 0, cycles = 0, m_dcnt = 0;
    logic [31:0] lfsr_state = 32'h2FAC30AB;
    code_char_s seq [10] = '{KC, '{1'b0, D16_2}, KC, '{1'b0, D10_1}, KC, KC,
        '{1'b0, D16_2}, '{1'b0, D10_1}, KC, '{1'b0, D16_2}};

    xcvr_mode_idle_ctrl #(.NCH(N), .LOCK_CYCLES(20)) xcvr_mode_idle_ctrl_i (.clk_sys, .sys_rst,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .iface_select, .output_enable,
        .channel_clock_select, .busy_mode_input, .ethernet_mode_pin, .pattern_test_enable,
        .pll_power_down, .pll_lock, .nibble_mode, .outputs_oe,
        .shared_tx_clock(link_clk & !channel_clock_select),
        .per_channel_tx_clock({N{link_clk & channel_clock_select}}), .tx_char, .tx_code_out,
        .tx_code_valid,
        .idle_deletable, .shared_rx_clock, .per_channel_rx_byte_clock, .tx_serial, .rx_serial);
    mac_model #(.NCH(N)) mac_model_i (.req, .next_char, .flip_bit(flip), .tx_serial, .link_clk,
        .tx_char, .rx_serial);

    always #5 clk_sys = ~clk_sys;
    // a hang is cut short well past the expected run length
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        lfsr_state = {lfsr_state[30:0], ^(lfsr_state & 32'h80200003)};
        return lfsr_state;
    endfunction : rnd
    // a quarter commas, many D16.2 so substitution is exercised often
    function automatic code_char_s rnd_char();
        logic [31:0] r;
        r = rnd();
        if (r[1:0] == 2'h0)
            return KC;
        return '{k: 1'b0, d: r[2] ? D16_2 : r[15:8]};
    endfunction : rnd_char
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic wcyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wcyc
    task automatic reg_write(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    // one character through the idle logic, checked against the idle model
    task automatic send_char(input code_char_s c);
        code_char_s e;
        logic del;
        e = c;
        del = m_prevk && !c.k && (ethernet_mode_pin ? (!busy_mode_input || c.d != D10_1)
                                                    : (!busy_mode_input && c.d == D10_1));
        if (ethernet_mode_pin && m_on && m_prevk && !c.k && c.d == D16_2)
            e.d = D5_6;
        // correction off on comma runs, on after two data
        if (c == KC)
        begin
            m_on = m_prevk ? 1'b0 : m_on;
            m_dcnt = 0;
        end
        else if (!m_on && ++m_dcnt == 2)
            m_on = 1'b1;
        m_prevk = (c == KC);
        next_char = c;
        req = ~req;
        @(posedge link_clk);
        for (int n = 0; n < 10 && tx_code_valid[0] !== 1'b1; n++)
            wcyc(1);
        // only the selected clock carries edges, so a wrong pick never shows valid
        check(tx_code_valid, {N{1'b1}});
        check(tx_code_out, {N{e}});
        check(idle_deletable, {N{del}});
        @(negedge link_clk);
    endtask : send_char

    initial
    begin
        logic [31:0] r;
        logic [13:0] sb;
        logic ph;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wcyc(10);
        check(pll_lock, 1'b0);
        wcyc(20);
        check(pll_lock, 1'b1);
        reg_write(ADDR_IRQ_MASK, 32'h7);
        wcyc(2);
        check(irq, 1'b1);
        reg_read(ADDR_IRQ_STAT, rd);
        check(rd, 32'h1);
        reg_read(ADDR_IRQ_STAT, rd);
        check(rd, 32'h0);
        check(irq, 1'b0);
        pll_power_down <= 1'b1;
        wcyc(4);
        check(pll_lock, 1'b0);
        pll_power_down <= 1'b0;
        wcyc(12);
        check(pll_lock, 1'b0);
        wcyc(20);
        check(pll_lock, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            iface_select <= r[0];
            output_enable <= r[1];
            channel_clock_select <= r[2];
            busy_mode_input <= r[3];
            ethernet_mode_pin <= r[4];
            reg_write(ADDR_CLK_CTRL, {16'h0, r[5], 15'h0});
            reg_write(ADDR_GE_CTRL, {16'h0, r[6], 15'h0});
            wcyc(12);
            reg_read(ADDR_STATUS, rd);
            check(rd, {25'h0, r[1], 2'h2, r[3], r[0], r[4] | r[6], r[2] | r[5]});
            check(nibble_mode, r[0]);
            check(outputs_oe, r[1]);
            check((r[2] | r[5]) ? shared_rx_clock : |per_channel_rx_byte_clock, 1'b0);
            // the selected receive clock must flip once per half period
            ph = (r[2] | r[5]) ? per_channel_rx_byte_clock[0] : shared_rx_clock;
            wcyc(RXCLK_HALF_DEF);
            check((r[2] | r[5]) ? per_channel_rx_byte_clock[0] : shared_rx_clock, !ph);
        end
        reg_read(8'h04, rd);
        check(rd, 32'h0);
        // pins alone pick clock and Ethernet mode from here on
        reg_write(ADDR_CLK_CTRL, 32'h0);
        reg_write(ADDR_GE_CTRL, 32'h0);
        for (int b = 0; b < 3; b++)
        begin
            ethernet_mode_pin <= b != 0;
            busy_mode_input <= b == 2;
            channel_clock_select <= b == 1;
            wcyc(4);
            foreach (seq[j])
                send_char(seq[j]);
            repeat (16)
                send_char(rnd_char());
        end
        reg_read(ADDR_IRQ_STAT, rd);
        check(rd[1], 1'b1);
        pattern_test_enable <= 1'b1;
        wcyc(400);
        reg_read(ADDR_PRBS, rd);
        check(rd, 32'h0000_00FF);
        // taps seven and six: each bit is the xor of the bits seven and six before it
        for (int k = 0; k < 14; k++)
        begin
            sb[k] = tx_serial[0];
            check(tx_serial, {N{sb[k]}});
            wcyc(BIT_DIV_DEF);
        end
        for (int k = 0; k < 7; k++)
            check(sb[k + 7], sb[k] ^ sb[k + 1]);
        check(sb == '0, 1'b0);
        flip <= 1'b1;
        wcyc(4);
        flip <= 1'b0;
        wcyc(40);
        reg_read(ADDR_PRBS, rd);
        check(rd, 32'h0000_FFFF);
        reg_read(ADDR_PRBS, rd);
        check(rd, 32'h0000_00FF);
        reg_read(ADDR_IRQ_STAT, rd);
        check(rd[2], 1'b1);
        give_verdict();
    end
endmodule : xcvr_mode_idle_ctrl_tb

bind xcvr_mode_idle_ctrl mode_idle_checker #(.NCH(NCH), .LOCK_CYCLES(LOCK_CYCLES))
    mode_idle_checker_i (.clk_sys, .sys_rst, .reg_rd, .reg_rdata, .iface_select, .output_enable,
    .channel_clock_select, .pattern_test_enable, .pll_power_down, .pll_lock, .nibble_mode,
    .outputs_oe, .shared_rx_clock, .per_channel_rx_byte_clock, .tx_serial);
